// *** core/eag_top.sv ***
// Effective address generator: mode decode, pointer fetch, block move
`timescale 1ns/100ps
module eag_top
  import eag_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 start,
  input  wire eag_mode_e            mode,
  input  wire logic [7:0]           op_lo,
  input  wire logic [7:0]           op_hi,
  input  wire logic [7:0]           op_bk,
  input  wire logic [OFFS_W-1:0]    direct_reg,
  input  wire logic [OFFS_W-1:0]    idx_x,
  input  wire logic [OFFS_W-1:0]    idx_y,
  input  wire logic [OFFS_W-1:0]    acc_in,
  input  wire logic [OFFS_W-1:0]    stack_ptr,
  input  wire logic [VEC_IDX_W-1:0] vec_idx,
  input  wire logic                 pc_step,
  input  wire logic                 db_load,
  input  wire logic [BANK_W-1:0]    db_value,
  input  wire logic [7:0]           rd_data,
  input  wire logic                 rd_valid,
  input  wire logic                 move_step,
  output logic                      busy_q,
  output logic      [EA_W-1:0]      ea_q,
  output logic                      ea_valid_q,
  output logic                      acc_op_q,
  output logic                      rd_req_q,
  output logic      [EA_W-1:0]      rd_addr_q,
  output logic      [OFFS_W-1:0]    pc_q,
  output logic      [BANK_W-1:0]    program_bank_q,
  output logic      [BANK_W-1:0]    data_bank_q,
  output logic                      pc_load_q,
  output logic      [EA_W-1:0]      src_addr_q,
  output logic      [EA_W-1:0]      dst_addr_q,
  output logic      [OFFS_W-1:0]    move_x_q,
  output logic      [OFFS_W-1:0]    move_y_q,
  output logic      [OFFS_W-1:0]    move_count_q,
  output logic                      move_done_q
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  eag_state_e          state_q;
  eag_state_e          state_d;
  eag_mode_e           mode_q;
  logic [1:0]          byte_q;
  logic [1:0]          byte_last;
  logic [OFFS_W-1:0]   ptr_base_q;
  logic [BANK_W-1:0]   src_bank_q;
  logic [BANK_W-1:0]   dst_bank_q;
  logic [OFFS_W-1:0]   op16;
  logic [EA_W-1:0]     op24;
  logic [OFFS_W-1:0]   dir_sum;
  logic [EA_W-1:0]     add_base;
  logic [OFFS_W-1:0]   add_offs;
  logic                add_b0;
  logic [EA_W-1:0]     add_sum;
  logic                take;
  logic                byte_in;
  logic                fetch_done;
  logic                ptr_mode;
  logic                jump_mode;
  logic                move_last;
  logic [OFFS_W-1:0]   x_next;
  logic [OFFS_W-1:0]   y_next;
  logic [EA_W-1:0]     ptr_val;

  eag_ptr_if ptr_link ();

  // ----------------------------------------------------------------
  // Operand assembly and mode classes
  // ----------------------------------------------------------------
  // first operand byte is the low byte
  assign op16    = {op_hi, op_lo};
  assign op24    = {op_bk, op_hi, op_lo};
  assign dir_sum = direct_reg + {8'h00, op_lo};
  assign take    = start && (state_q == EAG_IDLE);
  assign byte_in = (state_q == EAG_FETCH) && rd_req_q && rd_valid;
  assign ptr_val = ptr_link.value;

  assign ptr_mode  = (mode == EAG_DIR_X_IND) || (mode == EAG_DIR_IND_Y) ||
                     (mode == EAG_ABS_IND) || (mode == EAG_JUMP_LONG_IND) ||
                     (mode == EAG_ABS_X_IND);
  assign jump_mode = (mode_q == EAG_ABS_IND) || (mode_q == EAG_JUMP_LONG_IND) ||
                     (mode_q == EAG_ABS_X_IND);
  // long indirect jump reads a third byte
  assign byte_last  = (mode_q == EAG_JUMP_LONG_IND) ? PTR_LAST_LONG : PTR_LAST_SHORT;
  assign fetch_done = byte_in && (byte_q == byte_last);
  assign move_last  = (move_count_q == 16'h0000);

  // ascending steps up, descending steps down
  assign x_next = (mode_q == EAG_MOVE_ASC) ? move_x_q + IDX_STEP : move_x_q - IDX_STEP;
  assign y_next = (mode_q == EAG_MOVE_ASC) ? move_y_q + IDX_STEP : move_y_q - IDX_STEP;

  // ----------------------------------------------------------------
  // Adder operand selection
  // ----------------------------------------------------------------
  always_comb
  begin
    add_base = '0;
    add_offs = '0;
    add_b0   = 1'b0;
    case (state_q)
      EAG_IDLE:
      begin
        case (mode)
          EAG_ABS:
            add_base = {data_bank_q, op16};
          EAG_ABS_X:
          begin
            add_base = {data_bank_q, op16};
            add_offs = idx_x;
          end
          EAG_ABS_Y:
          begin
            add_base = {data_bank_q, op16};
            add_offs = idx_y;
          end
          EAG_LONG:
            add_base = op24;
          EAG_LONG_X:
          begin
            add_base = op24;
            add_offs = idx_x;
          end
          EAG_DIR, EAG_DIR_IND_Y:
          begin
            add_base = {BANK0, dir_sum};
            add_b0   = 1'b1;
          end
          EAG_DIR_X, EAG_DIR_X_IND:
          begin
            add_base = {BANK0, dir_sum};
            add_offs = idx_x;
            add_b0   = 1'b1;
          end
          EAG_DIR_Y:
          begin
            add_base = {BANK0, dir_sum};
            add_offs = idx_y;
            add_b0   = 1'b1;
          end
          EAG_ABS_IND, EAG_JUMP_LONG_IND:
          begin
            add_base = {BANK0, op16};
            add_b0   = 1'b1;
          end
          EAG_ABS_X_IND:
          begin
            add_base = {BANK0, op16};
            add_offs = idx_x;
            add_b0   = 1'b1;
          end
          EAG_STACK:
          begin
            add_base = {BANK0, stack_ptr};
            add_b0   = 1'b1;
          end
          EAG_STACK_REL:
          begin
            add_base = {BANK0, stack_ptr};
            add_offs = {8'h00, op_lo};
            add_b0   = 1'b1;
          end
          EAG_VECTOR:
          begin
            add_base = VEC_BASE;
            add_offs = {{(OFFS_W-VEC_IDX_W-1){1'b0}}, vec_idx, 1'b0};
            add_b0   = 1'b1;
          end
          default:
            add_base = op24;
        endcase
      end
      // Next pointer byte, wrapping in bank 0
      EAG_FETCH:
      begin
        add_base = {BANK0, ptr_base_q};
        add_offs = {14'h0000, byte_q + 2'h1};
        add_b0   = 1'b1;
      end
      EAG_RESOLVE:
      begin
        add_base = {data_bank_q, ptr_val[OFFS_W-1:0]};
        add_offs = (mode_q == EAG_DIR_IND_Y) ? idx_y : 16'h0000;
      end
      default:
        add_base = '0;
    endcase
  end

  eag_add #(
    .BASE_W (EA_W),
    .OFF_W  (OFFS_W)
  ) u_add (
    .base  (add_base),
    .offs  (add_offs),
    .bank0 (add_b0),
    .sum   (add_sum)
  );

  // ----------------------------------------------------------------
  // Pointer collection
  // ----------------------------------------------------------------
  assign ptr_link.clr  = take;
  assign ptr_link.load = byte_in;
  assign ptr_link.idx  = byte_q;
  assign ptr_link.data = rd_data;

  eag_ptr_asm u_ptr (
    .clk   (clk),
    .rst_b (rst_b),
    .pif   (ptr_link)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      EAG_IDLE:
        if (take && ptr_mode)
          state_d = EAG_FETCH;
        else if (take && ((mode == EAG_MOVE_ASC) || (mode == EAG_MOVE_DESC)))
          state_d = EAG_MOVE;
      EAG_FETCH:
        if (fetch_done)
          state_d = EAG_RESOLVE;
      EAG_RESOLVE:
        state_d = EAG_IDLE;
      EAG_MOVE:
        if (move_step && move_last)
          state_d = EAG_IDLE;
      default:
        state_d = EAG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= EAG_IDLE;
      busy_q  <= 1'b0;
      mode_q  <= EAG_ABS;
    end
    else
    begin
      state_q <= state_d;
      busy_q  <= (state_d != EAG_IDLE);
      if (take)
        mode_q <= mode;
    end
  end

  // ----------------------------------------------------------------
  // Memory read port for pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_req_q   <= 1'b0;
      rd_addr_q  <= '0;
      byte_q     <= 2'h0;
      ptr_base_q <= '0;
    end
    else if (take && ptr_mode)
    begin
      rd_req_q   <= 1'b1;
      rd_addr_q  <= add_sum;
      byte_q     <= 2'h0;
      ptr_base_q <= add_sum[OFFS_W-1:0];
    end
    else if (fetch_done)
      rd_req_q <= 1'b0;
    else if (byte_in)
    begin
      rd_addr_q <= add_sum;
      byte_q    <= byte_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Effective address output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ea_q       <= '0;
      ea_valid_q <= 1'b0;
      acc_op_q   <= 1'b0;
    end
    else
    begin
      ea_valid_q <= 1'b0;
      acc_op_q   <= take && (mode == EAG_ACC);
      if (take && !ptr_mode && (mode != EAG_ACC) &&
          (mode != EAG_MOVE_ASC) && (mode != EAG_MOVE_DESC))
      begin
        ea_q       <= add_sum;
        ea_valid_q <= 1'b1;
      end
      else if (state_q == EAG_RESOLVE)
      begin
        ea_valid_q <= 1'b1;
        if (mode_q == EAG_JUMP_LONG_IND)
          ea_q <= ptr_val;
        else if (jump_mode)
          ea_q <= {program_bank_q, ptr_val[OFFS_W-1:0]};
        else
          ea_q <= add_sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and program bank
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_q           <= PC_RST;
      program_bank_q <= PB_RST;
      pc_load_q      <= 1'b0;
    end
    else
    begin
      pc_load_q <= 1'b0;
      if (take && ((mode == EAG_CALL_LONG) || (mode == EAG_RETURN_LONG)))
      begin
        pc_q           <= op16;
        program_bank_q <= op_bk;
        pc_load_q      <= 1'b1;
      end
      else if ((state_q == EAG_RESOLVE) && jump_mode)
      begin
        pc_q      <= ptr_val[OFFS_W-1:0];
        pc_load_q <= 1'b1;
        if (mode_q == EAG_JUMP_LONG_IND)
          program_bank_q <= ptr_val[EA_W-1:OFFS_W];
      end
      else if ((state_q == EAG_MOVE) && move_step && move_last)
        pc_q <= pc_q + MOVE_ADV;
      else if (pc_step)
        pc_q <= pc_q + PC_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Data bank
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      data_bank_q <= DB_RST;
    else if (take && ((mode == EAG_MOVE_ASC) || (mode == EAG_MOVE_DESC)))
      data_bank_q <= op_lo;
    else if (db_load)
      data_bank_q <= db_value;
  end

  // ----------------------------------------------------------------
  // Block move registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_bank_q   <= BANK0;
      dst_bank_q   <= BANK0;
      move_x_q     <= '0;
      move_y_q     <= '0;
      move_count_q <= '0;
      src_addr_q   <= '0;
      dst_addr_q   <= '0;
      move_done_q  <= 1'b0;
    end
    else
    begin
      move_done_q <= 1'b0;
      if (take && ((mode == EAG_MOVE_ASC) || (mode == EAG_MOVE_DESC)))
      begin
        // banks from operand, offsets from X and Y
        dst_bank_q   <= op_lo;
        src_bank_q   <= op_hi;
        move_x_q     <= idx_x;
        move_y_q     <= idx_y;
        move_count_q <= acc_in;
        src_addr_q   <= {op_hi, idx_x};
        dst_addr_q   <= {op_lo, idx_y};
      end
      else if ((state_q == EAG_MOVE) && move_step)
      begin
        // step indices, count down to zero
        move_x_q   <= x_next;
        move_y_q   <= y_next;
        src_addr_q <= {src_bank_q, x_next};
        dst_addr_q <= {dst_bank_q, y_next};
        if (move_last)
          move_done_q <= 1'b1;
        else
          move_count_q <= move_count_q - IDX_STEP;
      end
    end
  end
endmodule

// *** core/eag_pkg.sv ***
// Constants, modes and states of the effective address generator
// Operation
// - 24-bit addresses: bank byte plus 16-bit offset
// - Vector fetches stay within 00FFE0..00FFFF
// - Stack and stack-relative addresses sit in bank 0
// - Direct and direct indexed addresses sit in bank 0
// - Program bank never changed by PC wrap
// - Only long jumps, calls, returns reload program bank
// - Data address arithmetic carries into the bank, except direct and stack
// - Absolute: data bank above two operand bytes
// - Indexed indirect jump: bank-0 pointer at operand+X
// - Absolute indexed: operand plus index, data bank
// - Indirect jump: pointer to PC, long loads bank
// - Long indexed: 24-bit operand plus X
// - Long: three operand bytes are the address
// - Accumulator mode issues no memory address
// - Block move: banks, offsets, count, data bank copy
// - Block move steps indices, count, then PC+3
// - Direct indexed indirect: bank-0 pointer, data bank prefix
// - Direct indexed: offset+direct+index, bank 0
// - Direct indirect indexed: pointer, data bank, plus Y
package eag_pkg;
  localparam int          EA_W      = 24;
  localparam int          OFFS_W    = 16;
  localparam int          BANK_W    = 8;
  localparam int          VEC_IDX_W = 4;
  localparam int          PTR_BYTES = 3;
  localparam logic [7:0]  BANK0     = 8'h00;
  localparam logic [23:0] VEC_BASE  = 24'h00FFE0;
  localparam logic [15:0] PC_STEP   = 16'h0001;
  localparam logic [15:0] MOVE_ADV  = 16'h0003;
  localparam logic [15:0] IDX_STEP  = 16'h0001;
  localparam logic [1:0]  PTR_LAST_SHORT = 2'h1;
  localparam logic [1:0]  PTR_LAST_LONG  = 2'h2;
  localparam logic [7:0]  DB_RST    = 8'h00;
  localparam logic [7:0]  PB_RST    = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;

  typedef enum logic [4:0] {
    EAG_ABS, EAG_ABS_X, EAG_ABS_Y, EAG_LONG, EAG_LONG_X, EAG_ACC,
    EAG_MOVE_ASC, EAG_MOVE_DESC, EAG_DIR, EAG_DIR_X, EAG_DIR_Y,
    EAG_DIR_X_IND, EAG_DIR_IND_Y, EAG_ABS_IND, EAG_JUMP_LONG_IND,
    EAG_ABS_X_IND, EAG_STACK, EAG_STACK_REL, EAG_VECTOR,
    EAG_CALL_LONG, EAG_RETURN_LONG
  } eag_mode_e;

  typedef enum logic [1:0] {
    EAG_IDLE    = 2'b00,
    EAG_FETCH   = 2'b01,
    EAG_RESOLVE = 2'b11,
    EAG_MOVE    = 2'b10
  } eag_state_e;
endpackage

// *** core/eag_ptr_if.sv ***
// Pointer byte collection link between sequencer and assembler
`timescale 1ns/100ps
interface eag_ptr_if;
  import eag_pkg::*;
  logic            clr;
  logic            load;
  logic [1:0]      idx;
  logic [7:0]      data;
  logic [EA_W-1:0] value;
  modport ctl  (output clr, output load, output idx, output data, input value);
  modport coll (input clr, input load, input idx, input data, output value);
endinterface

// *** core/eag_ptr_asm.sv ***
// Little-endian pointer assembler, one byte lane per entry
`timescale 1ns/100ps
module eag_ptr_asm
  import eag_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  eag_ptr_if.coll   pif
);
  logic [7:0] lane_q [PTR_BYTES];

  for (genvar g = 0; g < PTR_BYTES; g++)
  begin : g_lane
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        lane_q[g] <= 8'h00;
      else if (pif.clr)
        lane_q[g] <= 8'h00;
      else if (pif.load && (pif.idx == 2'(g)))
        lane_q[g] <= pif.data;
    end
  end

  assign pif.value = {lane_q[2], lane_q[1], lane_q[0]};
endmodule

// *** core/eag_add.sv ***
// Address adder with optional bank-0 wrap
`timescale 1ns/100ps
module eag_add
  import eag_pkg::*;
#(
  parameter int BASE_W = EA_W,
  parameter int OFF_W  = OFFS_W
)
(
  input  wire logic [BASE_W-1:0] base,
  input  wire logic [OFF_W-1:0]  offs,
  input  wire logic              bank0,
  output logic      [BASE_W-1:0] sum
);
  logic [BASE_W-1:0] full;

  // carry runs into the bank byte
  assign full = base + BASE_W'(offs);
  // Bank-0 results wrap inside the low offset field
  assign sum  = bank0 ? {{(BASE_W-OFF_W){1'b0}}, full[OFF_W-1:0]} : full;
endmodule

// *** dv/eag_chk.sv ***
// Port checker for the effective address generator
`timescale 1ns/100ps
module eag_chk
  import eag_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 start,
  input wire eag_mode_e            mode,
  input wire logic [7:0]           op_lo,
  input wire logic [7:0]           op_hi,
  input wire logic [7:0]           op_bk,
  input wire logic [OFFS_W-1:0]    idx_x,
  input wire logic [OFFS_W-1:0]    acc_in,
  input wire logic [VEC_IDX_W-1:0] vec_idx,
  input wire logic                 pc_step,
  input wire logic                 move_step,
  input wire logic                 busy_q,
  input wire logic [EA_W-1:0]      ea_q,
  input wire logic                 ea_valid_q,
  input wire logic                 acc_op_q,
  input wire logic                 rd_req_q,
  input wire logic [EA_W-1:0]      rd_addr_q,
  input wire logic [OFFS_W-1:0]    pc_q,
  input wire logic [BANK_W-1:0]    program_bank_q,
  input wire logic [BANK_W-1:0]    data_bank_q,
  input wire logic                 pc_load_q,
  input wire logic [OFFS_W-1:0]    move_count_q,
  input wire logic                 move_done_q
);
  logic go;
  logic mv_q;

  assign go = start && !busy_q;

  // Step pulses only count while a move owns the sequencer
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      mv_q <= 1'b0;
    else if (go)
      mv_q <= mode inside {EAG_MOVE_ASC, EAG_MOVE_DESC};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // --------------------
  // Address, bank, accumulator, PC and block move checks
  // --------------------
  chk_abs_addr: assert property (
    go && mode == EAG_ABS |=> ea_valid_q && ea_q == {$past(data_bank_q), $past(op_hi), $past(op_lo)})
    else $error("absolute address wrong");
  chk_long_x_sum: assert property (
    go && mode == EAG_LONG_X |=> ea_q == {$past(op_bk), $past(op_hi), $past(op_lo)} + $past(idx_x))
    else $error("long indexed address wrong");
  chk_dir_bank: assert property (
    go && mode inside {EAG_DIR, EAG_DIR_X, EAG_DIR_Y} |=> ea_valid_q && ea_q[23:16] == BANK0)
    else $error("direct address left bank 0");
  chk_stack_bank: assert property (
    go && mode inside {EAG_STACK, EAG_STACK_REL} |=> ea_valid_q && ea_q[23:16] == BANK0)
    else $error("stack address left bank 0");
  chk_vector_slot: assert property (
    go && mode == EAG_VECTOR |=> ea_q == VEC_BASE + {$past(vec_idx), 1'b0} && ea_q >= VEC_BASE)
    else $error("vector address wrong");
  chk_acc_quiet: assert property (
    go && mode == EAG_ACC |=> acc_op_q && !ea_valid_q && !rd_req_q ##1 !acc_op_q)
    else $error("accumulator used memory");
  chk_ind_ptr: assert property (
    go && mode == EAG_ABS_X_IND |=> rd_req_q && rd_addr_q == {BANK0, {$past(op_hi), $past(op_lo)} + $past(idx_x)})
    else $error("pointer address wrong");
  chk_bank_load: assert property (
    $changed(program_bank_q) |-> pc_load_q)
    else $error("bank changed without load");
  chk_pc_wrap: assert property (
    $past(rst_b) && $past(pc_step) && !pc_load_q && !move_done_q
      |-> pc_q == $past(pc_q) + 16'h0001 && $stable(program_bank_q))
    else $error("pc step wrong");
  chk_move_setup: assert property (
    go && mode inside {EAG_MOVE_ASC, EAG_MOVE_DESC}
      |=> busy_q && data_bank_q == $past(op_lo) && move_count_q == $past(acc_in))
    else $error("move setup wrong");
  chk_move_count: assert property (
    mv_q && busy_q && move_step && move_count_q != 16'h0000
      |=> move_count_q == $past(move_count_q) - 16'h0001 && !move_done_q)
    else $error("move count wrong");
  chk_move_done: assert property (
    mv_q && busy_q && move_step && move_count_q == 16'h0000 |=> move_done_q && pc_q == $past(pc_q) + MOVE_ADV)
    else $error("move end wrong");

  cov_long_ind: cover property (go && mode == EAG_JUMP_LONG_IND);
  cov_ptr_end: cover property ($fell(rd_req_q));
  cov_move_end: cover property (move_done_q);
  cov_pc_wrap: cover property (pc_step && pc_q == 16'hFFFF);
endmodule

bind eag_top eag_chk chk_u (.clk, .rst_b, .start, .mode, .op_lo, .op_hi, .op_bk, .idx_x,
  .acc_in, .vec_idx, .pc_step, .move_step, .busy_q, .ea_q, .ea_valid_q, .acc_op_q, .rd_req_q,
  .rd_addr_q, .pc_q, .program_bank_q, .data_bank_q, .pc_load_q, .move_count_q, .move_done_q);

// *** dv/eag_mem_model.sv ***
// Memory model answering pointer byte reads
`timescale 1ns/100ps
module eag_mem_model
  import eag_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            slow,
  input  wire logic            req,
  input  wire logic [EA_W-1:0] addr,
  output logic                 rd_valid,
  output logic      [7:0]      rd_data
);
  logic [7:0] junk_q = 8'h5C;
  logic       go_q   = 1'b0;

  // Junk outside valid cycles so a stale byte never passes
  always @(posedge clk)
  begin
    junk_q <= junk_q + 8'h3B;
    go_q   <= !slow || ($urandom_range(1) == 1);
  end

  assign rd_valid = req && go_q;
  assign rd_data  = rd_valid ? (addr[7:0] ^ addr[15:8] ^ 8'hA5) : junk_q;
endmodule

// *** dv/test_effective_address_generator.sv ***
// Self-checking bench for the effective address generator
`timescale 1ns/100ps
module test_effective_address_generator
  import eag_pkg::*;
;
`define CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", name, exp, got); \
    end \
  end

  logic        clk = 1'b0, rst_b = 1'b0, start = 1'b0, slow = 1'b0;
  eag_mode_e   mode = EAG_ABS;
  logic [7:0]  op_lo = 8'h00, op_hi = 8'h00, op_bk = 8'h00, db_value = 8'h00, rd_data;
  logic [15:0] direct_reg = 16'h0000, idx_x = 16'h0000, idx_y = 16'h0000;
  logic [15:0] acc_in = 16'h0000, stack_ptr = 16'h0000;
  logic [3:0]  vec_idx = 4'h0;
  logic        pc_step = 1'b0, db_load = 1'b0, move_step = 1'b0;
  logic        rd_valid, busy_q, ea_valid_q, acc_op_q, rd_req_q, pc_load_q, move_done_q;
  logic [23:0] ea_q, rd_addr_q, src_addr_q, dst_addr_q;
  logic [15:0] pc_q, move_x_q, move_y_q, move_count_q, pc_m = 16'h0000;
  logic [7:0]  program_bank_q, data_bank_q, db_m = 8'h00, pb_m = 8'h00;
  int          failures = 0, tests_run = 0;
  eag_mode_e   imm[$] = '{EAG_ABS, EAG_ABS_X, EAG_ABS_Y, EAG_LONG, EAG_LONG_X, EAG_DIR,
                          EAG_DIR_X, EAG_DIR_Y, EAG_STACK, EAG_STACK_REL, EAG_VECTOR};
  eag_mode_e   ptr[$] = '{EAG_DIR_X_IND, EAG_DIR_IND_Y, EAG_ABS_IND, EAG_JUMP_LONG_IND,
                          EAG_ABS_X_IND};

  always #5 clk = ~clk;

  eag_top dut_u (.clk, .rst_b, .start, .mode, .op_lo, .op_hi, .op_bk, .direct_reg, .idx_x,
    .idx_y, .acc_in, .stack_ptr, .vec_idx, .pc_step, .db_load, .db_value, .rd_data, .rd_valid,
    .move_step, .busy_q, .ea_q, .ea_valid_q, .acc_op_q, .rd_req_q, .rd_addr_q, .pc_q,
    .program_bank_q, .data_bank_q, .pc_load_q, .src_addr_q, .dst_addr_q, .move_x_q,
    .move_y_q, .move_count_q, .move_done_q);

  eag_mem_model mem_u (.clk(clk), .slow(slow), .req(rd_req_q), .addr(rd_addr_q),
    .rd_valid(rd_valid), .rd_data(rd_data));

  // --------------------
  // Reference model and drivers
  // --------------------
  function automatic logic [7:0] mb(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  function automatic logic [23:0] imm_ea(eag_mode_e m);
    case (m)
      EAG_ABS:       return {db_m, op_hi, op_lo};
      EAG_ABS_X:     return {db_m, op_hi, op_lo} + idx_x;
      EAG_ABS_Y:     return {db_m, op_hi, op_lo} + idx_y;
      EAG_LONG:      return {op_bk, op_hi, op_lo};
      EAG_LONG_X:    return {op_bk, op_hi, op_lo} + idx_x;
      EAG_DIR:       return {8'h00, direct_reg + op_lo};
      EAG_DIR_X:     return {8'h00, direct_reg + op_lo + idx_x};
      EAG_DIR_Y:     return {8'h00, direct_reg + op_lo + idx_y};
      EAG_STACK_REL: return {8'h00, stack_ptr + op_lo};
      default:       return VEC_BASE + {vec_idx, 1'b0};
    endcase
  endfunction

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for idle
  task automatic idle();
    for (int n = 0; busy_q !== 1'b0; n++)
    begin
      if (n == 200)
      begin
        failures++;
        stop_test();
      end
      @(posedge clk);
      #1;
    end
  endtask

  task automatic issue(eag_mode_e m);
    idle();
    @(posedge clk);
    start <= 1'b1;
    mode  <= m;
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask

  task automatic rnd();
    @(posedge clk);
    op_lo      <= 8'($urandom);
    op_hi      <= 8'($urandom);
    op_bk      <= 8'($urandom);
    direct_reg <= 16'($urandom);
    idx_x      <= 16'($urandom);
    idx_y      <= 16'($urandom);
    stack_ptr  <= 16'($urandom);
    vec_idx    <= 4'($urandom);
    slow       <= 1'($urandom);
    db_value   <= 8'($urandom);
    db_load    <= 1'b1;
    @(posedge clk);
    db_load <= 1'b0;
    #1;
    db_m = db_value;
    `CHK("data_bank", db_m, data_bank_q)
  endtask

  task automatic jump_run(eag_mode_e m);
    issue(m);
    pc_m = {op_hi, op_lo};
    pb_m = op_bk;
    `CHK("pc", pc_m, pc_q)
    `CHK("pbank", pb_m, program_bank_q)
    `CHK("pc_load", 1'b1, pc_load_q)
  endtask

  task automatic ptr_run(eag_mode_e m);
    logic [15:0] p, w;
    logic [23:0] e;
    case (m)
      EAG_DIR_X_IND: p = direct_reg + op_lo + idx_x;
      EAG_DIR_IND_Y: p = direct_reg + op_lo;
      EAG_ABS_X_IND: p = {op_hi, op_lo} + idx_x;
      default:       p = {op_hi, op_lo};
    endcase
    w = {mb(p + 16'h0001), mb(p)};
    issue(m);
    `CHK("rd_addr", {8'h00, p}, rd_addr_q)
    idle();
    `CHK("ptr_valid", 1'b1, ea_valid_q)
    if (m == EAG_JUMP_LONG_IND)
      pb_m = mb(p + 16'h0002);
    case (m)
      EAG_DIR_X_IND: e = {db_m, w};
      EAG_DIR_IND_Y: e = {db_m, w} + idx_y;
      default:       e = {pb_m, w};
    endcase
    `CHK("ptr_ea", e, ea_q)
    if (m inside {EAG_ABS_IND, EAG_ABS_X_IND, EAG_JUMP_LONG_IND})
    begin
      `CHK("ind_pc", w, pc_q)
      `CHK("ind_bank", pb_m, program_bank_q)
    end
  endtask

  task automatic move_run(eag_mode_e m, logic [15:0] cnt);
    logic [15:0] x, y, c, s;
    @(posedge clk);
    acc_in <= cnt;
    issue(m);
    x = idx_x;
    y = idx_y;
    c = cnt;
    s = (m == EAG_MOVE_ASC) ? 16'h0001 : 16'hFFFF;
    db_m = op_lo;
    `CHK("src", {op_hi, x}, src_addr_q)
    `CHK("dst", {op_lo, y}, dst_addr_q)
    `CHK("mv_bank", db_m, data_bank_q)
    for (int k = 0; k <= cnt; k++)
    begin
      @(posedge clk);
      move_step <= 1'b1;
      @(posedge clk);
      move_step <= 1'b0;
      #1;
      x += s;
      y += s;
      if (c != 16'h0000)
        c--;
      `CHK("mv_src", {op_hi, x}, src_addr_q)
      `CHK("mv_x", x, move_x_q)
      `CHK("mv_y", y, move_y_q)
      `CHK("mv_count", c, move_count_q)
      `CHK("mv_done", k == cnt, move_done_q)
    end
    pc_m += MOVE_ADV;
    `CHK("mv_pc", pc_m, pc_q)
  endtask

  // --------------------
  // Main sequence
  // --------------------
  initial
  begin
    void'($urandom(32'hB454));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      rnd();
      if (i == 0)
      begin
        @(posedge clk);
        op_hi <= 8'hFF;
        op_lo <= 8'hFF;
        idx_x <= 16'h0002;
        #1;
      end
      foreach (imm[k])
      begin
        issue(imm[k]);
        `CHK("ea_valid", 1'b1, ea_valid_q)
        if (imm[k] == EAG_STACK)
          `CHK("stack_bank", BANK0, ea_q[23:16])
        else
          `CHK("ea", imm_ea(imm[k]), ea_q)
      end
      issue(EAG_ACC);
      `CHK("acc_op", 1'b1, acc_op_q)
      foreach (ptr[k])
        ptr_run(ptr[k]);
      jump_run(i[0] ? EAG_CALL_LONG : EAG_RETURN_LONG);
    end
    @(posedge clk);
    op_hi <= 8'hFF;
    op_lo <= 8'hFE;
    jump_run(EAG_CALL_LONG);
    @(posedge clk);
    pc_step <= 1'b1;
    repeat (3) @(posedge clk);
    pc_step <= 1'b0;
    #1;
    pc_m += 16'h0003;
    `CHK("pc_wrap", pc_m, pc_q)
    `CHK("pc_keep", pb_m, program_bank_q)
    move_run(EAG_MOVE_ASC, 16'h0002);
    move_run(EAG_MOVE_DESC, 16'h0000);
    move_run(EAG_MOVE_DESC, 16'h0003);
    stop_test();
  end
endmodule
